/* File: logic/next_page_capture.v */
`timescale 1ns/1ps
`include "phy_regs_map.vh"

module next_page_capture (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // negotiation side
  input  wire        pageRxStrobe,
  input  wire        pageIsNext,
  input  wire [15:0] pageRxWord,
  input  wire        basePageTrue,
  input  wire        altNpEnable,
  input  wire        expansionRead,
  // register side
  output reg  [15:0] partnerWord,
  output reg         basePageFlag
);

  // ***************************************************
  // capture of the received next page word
  // ***************************************************
  // word is kept verbatim, so every field mirrors the partner
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      partnerWord <= `NP_RESET;
    end else if (pageRxStrobe && pageIsNext) begin
      partnerWord <= pageRxWord; // R1 R2 R3 R4 R5
    end
  end

  // ***************************************************
  // latching base page flag
  // ***************************************************
  // set wins over the clear of a read in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      basePageFlag <= 1'b0;
    end else if (altNpEnable && basePageTrue) begin
      basePageFlag <= 1'b1; // R17 R23
    end else if (expansionRead || !altNpEnable) begin
      basePageFlag <= 1'b0; // R17
    end
  end

endmodule // next_page_capture

/* File: logic/phy_config_status_regs.v */
// Function
// R1: next-page register bit 15 shows partner has more next pages.
// R2: bit 14 shows partner acknowledged our link code word.
// R3: bit 13 message-page flag; bits 10:0 message code or user data.
// R4: bit 12 shows partner can comply with the message.
// R5: bit 11 shows partner toggle bit as received.
// R6: config bit 14 forces link state to pass.
// R7: config bit 13 disables the twisted-pair transmitter.
// R8: config bit 12 bypasses scrambler and descrambler at 100 Mbps.
// R9: config bit 10 disables jabber correction in 10 Mbps.
// R10: heartbeat generated in 10 Mbps only when config bit 9 set.
// R11: config bit 8 suppresses half-duplex twisted-pair loopback in 10 Mbps.
// R12: config bit 7 extends carrier sense to data valid end in 10 Mbps.
// R13: config bit 6 enables sleep; bits 4:3 pick 3.04, 2.00, 1.04 seconds.
// R14: sleep enable bit loaded from sleep strap pin at reset.
// R15: config bit 5 gives preamble with carrier; always at 100 Mbps.
// R16: far-end fault sent only while config bit 2 set; reset one.
// R17: config bit 1 enables alternate next page and base-page flag.
// R18: config bit 0 selects fiber; reset from fiber-select strap.
// R19: status bit 14 set while running 100BASE-TX.
// R20: status bit 13 set while transmitting a packet.
// R21: status bit 12 set while receiving a packet.
// R22: status bit 11 set while a collision occurs.
// R23: base-page flag latches high when a base page was received.
// R24: writes to read-only registers and fields are ignored.
// R25: host writes zero to reserved config bits 15 and 11.
`timescale 1ns/1ps
`include "phy_regs_map.vh"

module phy_config_status_regs #(
  parameter        CNT_W     = 27,
  parameter [26:0] SLEEP_T0  = `SLEEP_T0_CYC,
  parameter [26:0] SLEEP_T1  = `SLEEP_T1_CYC,
  parameter [26:0] SLEEP_T2  = `SLEEP_T2_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // management register port
  input  wire [4:0]  mgmtAddr,
  input  wire        mgmtWrite,
  input  wire        mgmtRead,
  input  wire [15:0] mgmtWrData,
  output reg  [15:0] mgmtRdData,
  output reg         mgmtRdValid,
  // strap pins
  input  wire        sleepStrap,
  input  wire        fiber_select_strap,
  // negotiation engine
  input  wire        pageRxStrobe,
  input  wire        pageIsNext,
  input  wire [15:0] pageRxWord,
  input  wire        basePageTrue,
  input  wire        expansionRead,
  output reg         basePageFlag,
  output reg         altNpEnable,
  // line and media status
  input  wire        speed100,
  input  wire        fullDuplex,
  input  wire        linkRaw,
  input  wire        lineIdle,
  input  wire        txActive,
  input  wire        rxActive,
  input  wire        collision,
  // receive path
  input  wire        crsIn,
  input  wire        rxFrameIn,
  output reg         crsOut,
  output reg         rxDvOut,
  // transmit path and 10 Mbps functions
  input  wire        sqeRequest,
  output reg         linkStatus,
  output reg         txDisable,
  output reg         scramblerBypass,
  output reg         jabberDisable,
  output reg         heartbeatPulse,
  output reg         loopbackDisable,
  output reg         fefiEnable,
  output reg         fiberMode,
  output reg         sleepActive
);

  // ***************************************************
  // storage
  // ***************************************************
  reg  [15:0]      portConfig;
  reg              strapPending;
  reg  [3:0]       statusBits;
  reg  [CNT_W-1:0] sleepLimit;
  wire [15:0]      partnerWord;
  wire             basePageInt;
  wire             sleepInt;
  wire             cfgWrite;
  reg  [15:0]      next_rdData;
  reg              next_crs;
  reg              next_rxDv;

  // the only writable register is the port configuration
  assign cfgWrite = mgmtWrite && (mgmtAddr == `ADDR_PORT_CONFIGURATION); // R24

  // ***************************************************
  // port configuration register
  // ***************************************************
  // a constant under reset; straps are taken on the first edge
  // after release so reset never loads a pin value directly
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portConfig   <= `CFG_RESET; // R12 R16
      strapPending <= 1'b1;
    end else begin
      strapPending <= 1'b0;
      if (cfgWrite) begin
        portConfig <= mgmtWrData & `CFG_WRITABLE; // R25
      end else if (strapPending) begin
        portConfig[`CFG_SLEEP_EN] <= sleepStrap;         // R14
        portConfig[`CFG_FIBER]    <= fiber_select_strap; // R18
      end
    end
  end

  // ***************************************************
  // sleep period selection
  // ***************************************************
  // code 11 is unused; it disables the timer instead of guessing
  always @* begin
    case (portConfig[`CFG_SLEEP_SEL_HI:`CFG_SLEEP_SEL_LO])
      2'b00:   sleepLimit = SLEEP_T0[CNT_W-1:0]; // R13
      2'b01:   sleepLimit = SLEEP_T1[CNT_W-1:0]; // R13
      2'b10:   sleepLimit = SLEEP_T2[CNT_W-1:0]; // R13
      default: sleepLimit = {CNT_W{1'b0}};
    endcase
  end

  sleep_timer #(
    .CNT_W    (CNT_W)
  ) u_sleep (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (portConfig[`CFG_SLEEP_EN]),
    .lineIdle (lineIdle),
    .limit    (sleepLimit),
    .sleeping (sleepInt)
  );

  // ***************************************************
  // partner next page and base page flag
  // ***************************************************
  next_page_capture u_np (
    .clk           (clk),
    .rst_n         (rst_n),
    .pageRxStrobe  (pageRxStrobe),
    .pageIsNext    (pageIsNext),
    .pageRxWord    (pageRxWord),
    .basePageTrue  (basePageTrue),
    .altNpEnable   (portConfig[`CFG_ALT_NP]),
    .expansionRead (expansionRead),
    .partnerWord   (partnerWord),
    .basePageFlag  (basePageInt)
  );

  // ***************************************************
  // secondary status sampling
  // ***************************************************
  // levels only; no latching, they follow the line one clock late
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statusBits <= 4'h0;
    end else begin
      statusBits[3] <= speed100;  // R19
      statusBits[2] <= txActive;  // R20
      statusBits[1] <= rxActive;  // R21
      statusBits[0] <= collision; // R22
    end
  end

  // ***************************************************
  // receive path qualifiers
  // ***************************************************
  // preamble passes whenever enabled or at 100 Mbps; carrier
  // extension only applies to 10 Mbps reception
  always @* begin
    if (speed100 || portConfig[`CFG_PREAMBLE_EN]) begin
      next_rxDv = crsIn | rxFrameIn; // R15
    end else begin
      next_rxDv = rxFrameIn; // R15
    end
    next_crs = crsIn;
    if (!speed100 && portConfig[`CFG_CRS_EXTEND] && rxDvOut && next_rxDv) begin
      next_crs = 1'b1; // R12
    end
  end

  // ***************************************************
  // control outputs
  // ***************************************************
  // all registered so the core sees glitch-free controls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkStatus      <= 1'b0;
      txDisable       <= 1'b0;
      scramblerBypass <= 1'b0;
      jabberDisable   <= 1'b0;
      heartbeatPulse  <= 1'b0;
      loopbackDisable <= 1'b0;
      fefiEnable      <= 1'b0;
      fiberMode       <= 1'b0;
      altNpEnable     <= 1'b0;
      basePageFlag    <= 1'b0;
      sleepActive     <= 1'b0;
      crsOut          <= 1'b0;
      rxDvOut         <= 1'b0;
    end else begin
      linkStatus      <= linkRaw | portConfig[`CFG_FORCE_LINK];              // R6
      txDisable       <= portConfig[`CFG_TX_DISABLE];                        // R7
      scramblerBypass <= portConfig[`CFG_SCR_BYPASS] & speed100;             // R8
      jabberDisable   <= portConfig[`CFG_JABBER_DIS] & ~speed100;            // R9
      heartbeatPulse  <= sqeRequest & portConfig[`CFG_HEARTBEAT] & ~speed100; // R10
      loopbackDisable <= portConfig[`CFG_LOOPBACK_DIS] & ~speed100 & ~fullDuplex; // R11
      fefiEnable      <= portConfig[`CFG_FAULT_EN];                          // R16
      fiberMode       <= portConfig[`CFG_FIBER];                             // R18
      altNpEnable     <= portConfig[`CFG_ALT_NP];                            // R17
      basePageFlag    <= basePageInt;
      sleepActive     <= sleepInt;
      crsOut          <= next_crs;
      rxDvOut         <= next_rxDv;
    end
  end

  // ***************************************************
  // read multiplexer
  // ***************************************************
  // unmapped addresses answer zero rather than stale data
  always @* begin
    next_rdData = 16'h0000;
    case (mgmtAddr)
      `ADDR_PARTNER_NEXT_PAGE_RX: begin
        next_rdData = partnerWord; // R1 R2 R3 R4 R5
      end
      `ADDR_PORT_CONFIGURATION: begin
        next_rdData = portConfig;
      end
      `ADDR_SECONDARY_STATUS: begin
        next_rdData[`ST2_SPEED100]  = statusBits[3]; // R19
        next_rdData[`ST2_TX_ACTIVE] = statusBits[2]; // R20
        next_rdData[`ST2_RX_ACTIVE] = statusBits[1]; // R21
        next_rdData[`ST2_COLLISION] = statusBits[0]; // R22
        next_rdData[`ST2_LINK]      = linkStatus;
      end
      default: begin
        next_rdData = 16'h0000;
      end
    endcase
  end

  // ***************************************************
  // read answer
  // ***************************************************
  // data holds until the next read, valid is a one-cycle pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmtRdData  <= 16'h0000;
      mgmtRdValid <= 1'b0;
    end else begin
      mgmtRdValid <= mgmtRead;
      if (mgmtRead) begin
        mgmtRdData <= next_rdData;
      end
    end
  end

endmodule // phy_config_status_regs

/* File: logic/phy_regs_map.vh */
`ifndef PHY_REGS_MAP_VH
`define PHY_REGS_MAP_VH

// ***************************************************
// register addresses on the management port
// ***************************************************
`define ADDR_PARTNER_NEXT_PAGE_RX 5'h08
`define ADDR_PORT_CONFIGURATION   5'h10
`define ADDR_SECONDARY_STATUS     5'h11

// ***************************************************
// partner next-page receive fields
// ***************************************************
`define NP_MORE_BIT    15
`define NP_ACK_BIT     14
`define NP_MSG_BIT     13
`define NP_ACK2_BIT    12
`define NP_TOGGLE_BIT  11
`define NP_CODE_HI     10
`define NP_RESET       16'h0000

// ***************************************************
// port configuration fields
// ***************************************************
`define CFG_FORCE_LINK    14
`define CFG_TX_DISABLE    13
`define CFG_SCR_BYPASS    12
`define CFG_JABBER_DIS    10
`define CFG_HEARTBEAT     9
`define CFG_LOOPBACK_DIS  8
`define CFG_CRS_EXTEND    7
`define CFG_SLEEP_EN      6
`define CFG_PREAMBLE_EN   5
`define CFG_SLEEP_SEL_HI  4
`define CFG_SLEEP_SEL_LO  3
`define CFG_FAULT_EN      2
`define CFG_ALT_NP        1
`define CFG_FIBER         0
// reserved bits 15 and 11 are not stored and read as zero
`define CFG_WRITABLE      16'h77FF
`define CFG_RESET         16'h0084

// ***************************************************
// secondary status fields
// ***************************************************
`define ST2_SPEED100   14
`define ST2_TX_ACTIVE  13
`define ST2_RX_ACTIVE  12
`define ST2_COLLISION  11
`define ST2_LINK       10

// ***************************************************
// sleep timer, times in milliseconds
// ***************************************************
`define CLK_KHZ        20000
`define SLEEP_T0_MS    3040
`define SLEEP_T1_MS    2000
`define SLEEP_T2_MS    1040
`define SLEEP_T0_CYC   (`SLEEP_T0_MS * `CLK_KHZ)
`define SLEEP_T1_CYC   (`SLEEP_T1_MS * `CLK_KHZ)
`define SLEEP_T2_CYC   (`SLEEP_T2_MS * `CLK_KHZ)

`endif

/* File: logic/sleep_timer.v */
`timescale 1ns/1ps

module sleep_timer #(
  parameter CNT_W = 27
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // control
  input  wire             enable,
  input  wire             lineIdle,
  input  wire [CNT_W-1:0] limit,
  // result
  output reg              sleeping
);

  reg [CNT_W-1:0] idleCount;

  // ***************************************************
  // idle counter
  // ***************************************************
  // any line activity or disable restarts the whole period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idleCount <= {CNT_W{1'b0}};
      sleeping  <= 1'b0;
    end else if (!enable || !lineIdle || limit == {CNT_W{1'b0}}) begin
      idleCount <= {CNT_W{1'b0}};
      sleeping  <= 1'b0;
    end else if (idleCount >= limit - 1'b1) begin
      sleeping  <= 1'b1; // R13
    end else begin
      idleCount <= idleCount + 1'b1;
    end
  end

endmodule // sleep_timer

/* File: testbench/cfg_status_sva.sv */
`timescale 1ns/1ps
`include "phy_regs_map.vh"

// ************************
// register bank port checks
// ************************
module cfg_status_sva (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // register port
  input wire [4:0]  mgmtAddr,
  input wire        mgmtWrite,
  input wire        mgmtRead,
  input wire [15:0] mgmtWrData,
  input wire [15:0] mgmtRdData,
  // core inputs
  input wire        pageRxStrobe,
  input wire        pageIsNext,
  input wire [15:0] pageRxWord,
  input wire        speed100,
  input wire        txActive,
  input wire        rxActive,
  input wire        collision,
  input wire        sqeRequest,
  // derived outputs
  input wire        heartbeatPulse,
  input wire        txDisable,
  input wire        fefiEnable,
  input wire        altNpEnable,
  input wire        fiberMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // decoded strobes keep the properties short
  wire cfgWr = mgmtWrite && mgmtAddr == `ADDR_PORT_CONFIGURATION;
  wire npRd  = mgmtRead && mgmtAddr == `ADDR_PARTNER_NEXT_PAGE_RX;
  wire stRd  = mgmtRead && mgmtAddr == `ADDR_SECONDARY_STATUS;
  wire badRd = mgmtRead && !npRd && !stRd && mgmtAddr != `ADDR_PORT_CONFIGURATION;

  tx_disable_a: assert property (cfgWr |-> ##2 txDisable == $past(mgmtWrData[13], 2))
    else $error("tx disable mismatch");
  fault_enable_a: assert property (cfgWr |-> ##2 fefiEnable == $past(mgmtWrData[2], 2))
    else $error("fault enable mismatch");
  alt_np_a: assert property (cfgWr |-> ##2 altNpEnable == $past(mgmtWrData[1], 2))
    else $error("alt next page mismatch");
  fiber_mode_a: assert property (cfgWr |-> ##2 fiberMode == $past(mgmtWrData[0], 2))
    else $error("fiber mode mismatch");
  status_bits_a: assert property (
    stRd |=> mgmtRdData[15:11] == {1'b0, $past({speed100, txActive, rxActive, collision}, 2)})
    else $error("activity bits mismatch");
  next_page_a: assert property (
    (pageRxStrobe && pageIsNext) ##1 !pageRxStrobe ##1 npRd |=> mgmtRdData == $past(pageRxWord, 3))
    else $error("next page word mismatch");
  heartbeat_gate_a: assert property (heartbeatPulse |-> $past(sqeRequest && !speed100))
    else $error("heartbeat without cause");
  unmapped_zero_a: assert property (badRd |=> mgmtRdData == 16'h0000)
    else $error("unmapped read not zero");
endmodule // cfg_status_sva

bind phy_config_status_regs cfg_status_sva chk (.*);

/* File: testbench/mgmt_host.sv */
`timescale 1ns/1ps

// ************************
// management host model
// ************************
module mgmt_host (
  // clock
  input  wire         clk,
  // register port
  output logic [4:0]  mgmtAddr,
  output logic        mgmtWrite,
  output logic        mgmtRead,
  output logic [15:0] mgmtWrData
);
  // idle from time zero
  initial begin
    {mgmtAddr, mgmtWrite, mgmtRead, mgmtWrData} = 23'h000000;
  end
  // one strobe cycle, taken at the following edge
  task xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmtWrite  <= w;
    mgmtRead   <= !w;
    mgmtAddr   <= a;
    mgmtWrData <= d;
    @(posedge clk);
    mgmtWrite  <= 1'b0;
    mgmtRead   <= 1'b0;
    // released lines flip so stale values cannot pass
    mgmtAddr   <= ~a;
    mgmtWrData <= ~d;
  endtask
endmodule // mgmt_host

/* File: testbench/phy_config_status_regs_bench.sv */
`timescale 1ns/1ps
`include "phy_regs_map.vh"

// ************************
// register bank bench
// ************************
module phy_config_status_regs_bench;
  logic        clk, rst_n, sleepStrap, fiber_select_strap, pageRxStrobe, pageIsNext, basePageTrue;
  logic        expansionRead, speed100, fullDuplex, linkRaw, lineIdle, txActive, rxActive;
  logic        collision, crsIn, rxFrameIn, sqeRequest;
  logic [15:0] pageRxWord, cfg, np;
  logic [31:0] seed, r, q;
  logic [31:0] expq [$];
  int          bad_count, n_compared, i;
  int          lims [4] = '{20, 15, 10, 10};
  wire  [4:0]  mgmtAddr;
  wire  [15:0] mgmtWrData, mgmtRdData;
  wire         mgmtWrite, mgmtRead, mgmtRdValid, basePageFlag, altNpEnable, crsOut, rxDvOut, linkStatus;
  wire         txDisable, scramblerBypass, jabberDisable, heartbeatPulse, loopbackDisable, fefiEnable;
  wire         fiberMode, sleepActive;

  // short sleep limits keep the run brief
  phy_config_status_regs #(.SLEEP_T0(27'd20), .SLEEP_T1(27'd15), .SLEEP_T2(27'd10)) uut (
    .clk, .rst_n, .mgmtAddr, .mgmtWrite, .mgmtRead, .mgmtWrData, .mgmtRdData, .mgmtRdValid,
    .sleepStrap, .fiber_select_strap, .pageRxStrobe, .pageIsNext, .pageRxWord, .basePageTrue,
    .expansionRead, .basePageFlag, .altNpEnable, .speed100, .fullDuplex, .linkRaw, .lineIdle,
    .txActive, .rxActive, .collision, .crsIn, .rxFrameIn, .crsOut, .rxDvOut, .sqeRequest,
    .linkStatus, .txDisable, .scramblerBypass, .jabberDisable, .heartbeatPulse, .loopbackDisable,
    .fefiEnable, .fiberMode, .sleepActive);
  mgmt_host host (.clk, .mgmtAddr, .mgmtWrite, .mgmtRead, .mgmtWrData);

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // the note goes in before the strobe so the watcher always finds it
  task rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    expq.push_back({m, e});
    host.xfer(1'b0, a, 16'h0000);
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    if (a == `ADDR_PORT_CONFIGURATION) cfg = d & `CFG_WRITABLE;
    host.xfer(1'b1, a, d);
  endtask
  // outputs are looked at mid-cycle, away from the edge
  task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task close_out;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // read answers matched with the oldest note
  always @(posedge clk) begin
    if (mgmtRdValid === 1'b1) begin
      q = expq.pop_front();
      chk(mgmtRdData & q[31:16], q[15:0]);
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // watchdog, run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    close_out;
  end
  initial begin
    seed = 32'hcdf7;
    r = $random(seed);
    {rst_n, pageRxStrobe, pageIsNext, basePageTrue, expansionRead, lineIdle, sqeRequest} = 7'h00;
    {speed100, fullDuplex, linkRaw, txActive, rxActive, collision, crsIn, rxFrameIn} = 8'h00;
    {sleepStrap, fiber_select_strap} = r[1:0];
    pageRxWord = 16'h0000;
    np = `NP_RESET;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cfg = `CFG_RESET | {9'h000, r[1], 5'h00, r[0]};
    settle(3);
    chk({14'h0, fefiEnable, fiberMode}, {14'h0, 1'b1, r[0]});
    rd(`ADDR_PORT_CONFIGURATION, 16'hFFFF, cfg);
    rd(5'h05, 16'hFFFF, 16'h0000);
    wr(`ADDR_PARTNER_NEXT_PAGE_RX, 16'hFFFF);
    rd(`ADDR_PARTNER_NEXT_PAGE_RX, 16'hFFFF, `NP_RESET);
    $display("reset values done");
    for (i = 0; i < 5; i++) begin
      r = $random(seed);
      wr(`ADDR_PORT_CONFIGURATION, (i == 4) ? 16'hFFFF : r[15:0]);
      rd(`ADDR_PORT_CONFIGURATION, 16'hFFFF, cfg);
      settle(1);
      chk({12'h0, txDisable, cfg[2:0]}, {12'h0, cfg[13], fefiEnable, altNpEnable, fiberMode});
    end
    $display("config writes done");
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      @(posedge clk);
      pageRxStrobe <= 1'b1;
      pageIsNext   <= (i != 2);
      pageRxWord   <= r[15:0];
      if (i != 2) np = r[15:0];
      @(posedge clk);
      pageRxStrobe <= 1'b0;
      pageRxWord   <= ~r[15:0];
      rd(`ADDR_PARTNER_NEXT_PAGE_RX, 16'hFFFF, np);
    end
    $display("next page done");
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      @(posedge clk);
      {speed100, linkRaw, txActive, rxActive, collision, fullDuplex, crsIn, rxFrameIn} <= r[7:0];
      sqeRequest <= r[8];
      if (i == 0) wr(`ADDR_SECONDARY_STATUS, 16'hFFFF);
      settle(2);
      rd(`ADDR_SECONDARY_STATUS, 16'hFC00, {1'b0, r[7], r[5:3], r[6] | cfg[14], 10'h000});
    end
    $display("status done");
    // 10 Mbps half duplex twice, then 100 Mbps
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      {speed100, fullDuplex, sqeRequest} <= {i == 2, 2'b01};
      wr(`ADDR_PORT_CONFIGURATION, (i == 0) ? 16'h0000 : 16'h1700);
      settle(3);
      chk({12'h0, scramblerBypass, jabberDisable, heartbeatPulse, loopbackDisable},
          {12'h0, i == 2, {3{i == 1}}});
    end
    $display("line functions done");
    // carrier high with no frame, then frame with carrier gone
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {speed100, crsIn, rxFrameIn} <= {i[1], 2'b10};
      wr(`ADDR_PORT_CONFIGURATION, i[0] ? 16'h00A0 : 16'h0000);
      settle(2);
      chk({14'h0, crsOut, rxDvOut}, {14'h0, 1'b1, i != 0});
      @(posedge clk);
      {crsIn, rxFrameIn} <= 2'b01;
      settle(2);
      chk({14'h0, crsOut, rxDvOut}, {14'h0, i == 1, 1'b1});
    end
    {crsIn, rxFrameIn} <= 2'b00;
    $display("receive path done");
    for (i = 0; i < 2; i++) begin
      wr(`ADDR_PORT_CONFIGURATION, (i == 0) ? 16'h0002 : 16'h0000);
      @(posedge clk);
      basePageTrue <= 1'b1;
      @(posedge clk);
      basePageTrue <= 1'b0;
      settle(4);
      chk({15'h0, basePageFlag}, {15'h0, i == 0});
      @(posedge clk);
      expansionRead <= 1'b1;
      @(posedge clk);
      expansionRead <= 1'b0;
      settle(3);
      chk({15'h0, basePageFlag}, 16'h0000);
    end
    $display("base page done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      lineIdle <= 1'b0;
      wr(`ADDR_PORT_CONFIGURATION, {9'h000, 2'b10, i[1:0], 3'h0});
      settle(3);
      @(posedge clk);
      lineIdle <= 1'b1;
      settle(lims[i] - 3);
      chk({15'h0, sleepActive}, 16'h0000);
      settle(8);
      chk({15'h0, sleepActive}, {15'h0, i != 3});
    end
    $display("sleep timer done");
    settle(3);
    close_out;
  end
endmodule // phy_config_status_regs_bench
